/* File: bench/drive_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_side_model (
  // clock
  input wire logic clk,
  // scenario commands from the bench
  input wire logic cal_cmd,
  input wire logic [5:0] trip_cmd,
  input wire logic [2:0] window_cmd,
  input wire logic [2:0] off_cmd,
  // controller and bridge pins toward the block
  output logic cal_pin,
  output logic [2:0] low_side_off_cmd,
  output logic [2:0] gate_drive_window,
  output logic [5:0] vds_over_trip
);
  // pins move only just after an edge, like a real controller port
  always_ff @(posedge clk) begin
    cal_pin <= cal_cmd;
    // bridges parked while trimming, so no switching noise
    low_side_off_cmd <= cal_cmd ? 3'h7 : off_cmd;
    gate_drive_window <= cal_cmd ? 3'h0 : window_cmd;
    vds_over_trip <= trip_cmd;
  end
endmodule : drive_side_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "shunt_amp_defs.svh"
module testbench;
  import shunt_amp_pkg::*;
  localparam int TRIM = 20;
  logic clk, rstn, cyc, stb, we, ack, cal_cmd, cal_pin, fault_flag_n, ref_bid;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, dat_o;
  logic [5:0] trip_cmd, vds_over_trip, overcurrent;
  logic [2:0] window_cmd, off_cmd, ls_off, window, low_side_ref_select_neg, shorted, disc, trim_run, amp_en, pos_sw;
  logic [4:0] trip_level;
  logic [1:0] amp_gain;
  int n_fail, n_tests, g;
  shunt_amp_cal_and_vds_monitor_ctrl #(.TRIM_CYCLES(TRIM)) DUT (.clk(clk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cal_pin(cal_pin), .low_side_off_cmd(ls_off),
    .gate_drive_window(window), .vds_over_trip(vds_over_trip), .drain_source_trip_level(trip_level),
    .amp_gain(amp_gain), .ref_bidirectional(ref_bid), .low_side_ref_select_neg(low_side_ref_select_neg), .amp_inputs_shorted(shorted),
    .amp_load_disconnect(disc), .amp_trim_run(trim_run), .amp_enable(amp_en),
    .pos_to_switch_node(pos_sw), .fault_flag_n(fault_flag_n), .overcurrent(overcurrent));
  drive_side_model far_side (.clk(clk), .cal_cmd(cal_cmd), .trip_cmd(trip_cmd), .window_cmd(window_cmd),
    .off_cmd(off_cmd), .cal_pin(cal_pin), .low_side_off_cmd(ls_off), .gate_drive_window(window),
    .vds_over_trip(vds_over_trip));
  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one classic cycle; ack and read data are taken at the rising edge that shows ack high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      end_of_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  initial begin
    rstn = 1'b0;
    {cyc, stb, we, adr, wdat, cal_cmd, trip_cmd, window_cmd, off_cmd} = '0;
    n_fail = 0;
    n_tests = 0;
    tick(5);
    rstn <= 1'b1;
    tick(3);
    chk("ref after reset", 1, ref_bid);
    bus(0, `REG_CTRL, 0);
    chk("ctrl reset", `CTRL_RESET, rdat);
    // every gain code in turn
    for (g = 0; g < 4; g++) begin
      bus(1, `REG_CTRL, g);
      tick(3);
      chk("amp_gain", g, amp_gain);
    end
    bus(1, `REG_CTRL, 32'h1f05);
    tick(3);
    chk("trip level", 5'h1f, trip_level);
    chk("unidirectional", 0, ref_bid);
    chk("low_side_ref_select pos", 0, low_side_ref_select_neg);
    bus(1, `REG_CTRL, 32'h1f0d);
    tick(3);
    chk("low_side_ref_select neg", 3'h7, low_side_ref_select_neg);
    // sense mode overrides the reference select bit
    bus(1, `REG_CTRL, 32'h1f15);
    tick(3);
    chk("ds ref", 3'h7, low_side_ref_select_neg);
    chk("switch node", 3'h7, pos_sw);
    window_cmd <= 3'h7;
    tick(12);
    chk("amp off in window", 0, amp_en);
    window_cmd <= 3'h0;
    off_cmd <= 3'h1;
    tick(12);
    chk("amp enable", 3'h6, amp_en);
    chk("off short", 1, shorted[0]);
    off_cmd <= 3'h0;
    bus(1, `REG_CTRL, 32'h1f05);
    tick(12);
    // register-started calibration on channel 0
    bus(1, `REG_CAL, 1);
    tick(4);
    chk("cal gain", `GAIN_CAL_CODE, amp_gain);
    chk("cal ref", 1, ref_bid);
    chk("cal short", 3'h1, shorted);
    chk("cal load", 3'h1, disc);
    chk("trim run", 3'h1, trim_run);
    tick(TRIM + 5);
    bus(0, `REG_CAL, 0);
    chk("cal status", 32'h49, rdat);
    chk("hold short", 3'h1, shorted);
    chk("trim over", 0, trim_run);
    bus(1, `REG_CAL, 0);
    tick(4);
    chk("gain back", 1, amp_gain);
    chk("ref back", 0, ref_bid);
    // a two-cycle glitch on the pin must be filtered out
    cal_cmd <= 1'b1;
    tick(2);
    cal_cmd <= 1'b0;
    tick(12);
    chk("pin glitch", 0, shorted);
    cal_cmd <= 1'b1;
    tick(12);
    chk("pin cal", 3'h7, shorted);
    cal_cmd <= 1'b0;
    tick(12);
    chk("pin gain back", 1, amp_gain);
    // short trip ignored, long trip flagged
    bus(1, `REG_DEGLITCH, 5);
    trip_cmd <= 6'h08;
    tick(4);
    trip_cmd <= 6'h00;
    tick(10);
    chk("short trip", 0, overcurrent);
    trip_cmd <= 6'h08;
    tick(14);
    chk("long trip", 6'h08, overcurrent);
    chk("fault pin", 0, fault_flag_n);
    trip_cmd <= 6'h00;
    bus(0, `REG_STATUS, 0);
    chk("status", 32'h48, rdat);
    bus(1, `REG_STATUS, 32'h08);
    bus(0, `REG_STATUS, 0);
    chk("status clear", 32'h40, rdat);
    // live fault reporting, then fault pin masked
    bus(1, `REG_CTRL, 32'h3f05);
    trip_cmd <= 6'h01;
    tick(14);
    chk("hs trip", 6'h01, overcurrent);
    chk("live fault", 0, fault_flag_n);
    trip_cmd <= 6'h00;
    tick(8);
    chk("live fault gone", 1, fault_flag_n);
    bus(1, `REG_CTRL, 32'h5f05);
    trip_cmd <= 6'h01;
    tick(14);
    chk("fault masked", 1, fault_flag_n);
    trip_cmd <= 6'h00;
    bus(0, 8'h10, 0);
    chk("unmapped", 0, rdat);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

/* File: hdl/shunt_amp_cal_and_vds_monitor_ctrl.sv */
// Operation
// RULE1: flag overcurrent after continuous trip beyond deglitch
// RULE2: programmable trip level selects comparator threshold
// RULE3: deglitch logic inputs against short noise
// RULE4: low-side reference picks positive or negative shunt
// RULE5: four gain levels 5/10/20/40
// RULE6: reference-halving off gives unidirectional amplifiers
// RULE7: calibration shorts inputs, disconnects load, forces 40
// RULE8: automatic trim completes in fixed 100 us
// RULE9: after trim keep short, disconnect, gain while requested
// RULE10: request low ends calibration, gain restored
// RULE11: any calibration forces shared reference bidirectional
// RULE12: controller calibrates while transistors are idle
// RULE13: drain-source sense routes positive input to switch node
// RULE14: drain-source sense forces negative shunt reference
// RULE15: sense mode enables at window end, shorts when off
// RULE16: per-channel request, state and trim counter
`timescale 1ns/100ps
`default_nettype none
`include "shunt_amp_defs.svh"
module shunt_amp_cal_and_vds_monitor_ctrl
  import shunt_amp_pkg::*;
#(
  parameter int CHANNELS = 3,
  parameter int TRIM_CYCLES = `TRIM_CYCLES,
  parameter int IN_DEGLITCH = `IN_DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins from outside
  input wire logic cal_pin,
  input wire logic [CHANNELS-1:0] low_side_off_cmd,
  input wire logic [CHANNELS-1:0] gate_drive_window,
  input wire logic [2*CHANNELS-1:0] vds_over_trip,
  // analog controls, fault flag and overcurrent outputs
  output logic [4:0] drain_source_trip_level,
  output logic [1:0] amp_gain,
  output logic ref_bidirectional,
  output logic [CHANNELS-1:0] low_side_ref_select_neg,
  output logic [CHANNELS-1:0] amp_inputs_shorted,
  output logic [CHANNELS-1:0] amp_load_disconnect,
  output logic [CHANNELS-1:0] amp_trim_run,
  output logic [CHANNELS-1:0] amp_enable,
  output logic [CHANNELS-1:0] pos_to_switch_node,
  output logic fault_flag_n,
  output logic [2*CHANNELS-1:0] overcurrent
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 8) $error("CHANNELS out of range");
    if (TRIM_CYCLES < 2 || IN_DEGLITCH < 1) $error("timing count too small");
  end

  localparam int CW = $clog2(TRIM_CYCLES + 1);
  localparam int NM = 2 * CHANNELS;

  // reset release through two flops
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // pin synchronisers: pins, gate window, comparators
  localparam int NP = 1 + 2 * CHANNELS + NM;
  logic [NP-1:0] pin_meta, pin_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {vds_over_trip, gate_drive_window, low_side_off_cmd, cal_pin};
      pin_sync <= pin_meta;
    end
  end

  // input deglitch: a level must hold IN_DEGLITCH cycles to pass
  localparam int NL = 1 + 2 * CHANNELS;
  localparam int DW = $clog2(IN_DEGLITCH + 1);
  logic [NL-1:0] clean;
  logic [DW-1:0] dg_cnt [NL];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clean <= '0;
      for (int i = 0; i < NL; i++) dg_cnt[i] <= '0;
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (pin_sync[i] == clean[i]) dg_cnt[i] <= '0;
        else if (dg_cnt[i] == DW'(IN_DEGLITCH - 1)) begin
          clean[i] <= pin_sync[i]; // RULE3
          dg_cnt[i] <= '0;
        end else dg_cnt[i] <= dg_cnt[i] + 1'b1;
      end
    end
  end
  logic cal_pin_clean;
  logic [CHANNELS-1:0] ls_off, drive_win;
  logic [NM-1:0] trip;
  assign cal_pin_clean = clean[0];
  assign ls_off = clean[CHANNELS:1];
  assign drive_win = clean[2*CHANNELS:CHANNELS+1];
  assign trip = pin_sync[NP-1:NL];

  // registers
  logic [31:0] ctrl;
  logic [CHANNELS-1:0] cal_reg;
  logic [15:0] deglitch_cycles;
  logic [NM-1:0] oc_sticky;
  logic bus_req, wr_en;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write lands on the edge at which the master sees ack high, not a cycle before
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // register writes with byte enables; overcurrent cleared by write-one
  logic [NM-1:0] oc_event;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
      cal_reg <= '0;
      deglitch_cycles <= `DEGLITCH_RESET;
      oc_sticky <= '0;
    end else begin
      if (wr_en && wb_adr_i == `REG_CTRL) begin
        for (int b = 0; b < 4; b++) if (wb_sel_i[b]) ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
      end else if (wr_en && wb_adr_i == `REG_CAL && wb_sel_i[0]) begin
        cal_reg <= wb_dat_i[CHANNELS-1:0];
      end else if (wr_en && wb_adr_i == `REG_DEGLITCH) begin
        if (wb_sel_i[0]) deglitch_cycles[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) deglitch_cycles[15:8] <= wb_dat_i[15:8];
      end
      // set wins over clear
      if (wr_en && wb_adr_i == `REG_STATUS && wb_sel_i[0])
        oc_sticky <= (oc_sticky & ~wb_dat_i[NM-1:0]) | oc_event;
      else oc_sticky <= oc_sticky | oc_event;
    end
  end

  // read mux and single-cycle ack
  logic [CHANNELS-1:0] cal_active, trim_done;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == `REG_CTRL) wb_dat_o <= ctrl;
        else if (wb_adr_i == `REG_CAL) wb_dat_o <= 32'({trim_done, cal_active, cal_reg});
        else if (wb_adr_i == `REG_STATUS) wb_dat_o <= 32'({amp_gain, oc_sticky});
        else if (wb_adr_i == `REG_DEGLITCH) wb_dat_o <= 32'(deglitch_cycles);
        else wb_dat_o <= '0;
      end
    end
  end

  // overcurrent deglitch: trip must stay high beyond the programmed count
  logic [15:0] oc_cnt [NM];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrent <= '0;
      for (int i = 0; i < NM; i++) oc_cnt[i] <= '0;
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (!trip[i]) begin
          oc_cnt[i] <= '0;
          overcurrent[i] <= 1'b0;
        end else if (oc_cnt[i] != deglitch_cycles) oc_cnt[i] <= oc_cnt[i] + 1'b1;
        else overcurrent[i] <= 1'b1; // RULE1
      end
    end
  end
  logic [NM-1:0] oc_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oc_prev <= '0;
    else oc_prev <= overcurrent;
  end
  assign oc_event = overcurrent & ~oc_prev;

  // fault mode: 0 latch sticky, 1 report live, 2 and 3 report only in status
  logic [1:0] fault_mode;
  assign fault_mode = ctrl[`CTRL_FAULT_MODE_LSB +: 2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fault_flag_n <= 1'b1;
    else if (fault_mode == 2'h0) fault_flag_n <= ~|oc_sticky; // RULE1
    else if (fault_mode == 2'h1) fault_flag_n <= ~|overcurrent;
    else fault_flag_n <= 1'b1;
  end

  // per-channel calibration machines
  logic [CHANNELS-1:0] cal_req;
  assign cal_req = cal_reg | {CHANNELS{cal_pin_clean}}; // RULE7
  cal_state_t cal_st [CHANNELS];
  logic [CW-1:0] trim_cnt [CHANNELS];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        cal_st[c] <= CAL_IDLE;
        trim_cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        case (cal_st[c])
          CAL_IDLE: begin
            trim_cnt[c] <= '0;
            if (cal_req[c]) cal_st[c] <= CAL_TRIM; // RULE16
          end
          CAL_TRIM: begin
            if (!cal_req[c]) cal_st[c] <= CAL_IDLE; // RULE10
            else if (trim_cnt[c] == CW'(TRIM_CYCLES - 1)) cal_st[c] <= CAL_HOLD; // RULE8
            else trim_cnt[c] <= trim_cnt[c] + 1'b1;
          end
          CAL_HOLD: begin
            if (!cal_req[c]) cal_st[c] <= CAL_IDLE; // RULE9 RULE10
          end
          default: cal_st[c] <= CAL_IDLE;
        endcase
      end
    end
  end

  // analog controls from calibration and sense mode
  logic any_cal, ds_sense;
  assign ds_sense = ctrl[`CTRL_DS_SENSE];
  assign any_cal = |cal_active;
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      cal_active[c] = cal_st[c] != CAL_IDLE;
      trim_done[c] = cal_st[c] == CAL_HOLD;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_source_trip_level <= '0;
      amp_gain <= GAIN_5;
      ref_bidirectional <= 1'b1;
      low_side_ref_select_neg <= '0;
      amp_inputs_shorted <= '0;
      amp_load_disconnect <= '0;
      amp_trim_run <= '0;
      amp_enable <= '0;
      pos_to_switch_node <= '0;
    end else begin
      drain_source_trip_level <= ctrl[`CTRL_TRIP_LSB +: 5]; // RULE2
      // gain forced while any channel calibrates; configured value returns
      amp_gain <= any_cal ? `GAIN_CAL_CODE : ctrl[`CTRL_GAIN_LSB +: 2]; // RULE5 RULE7 RULE10
      ref_bidirectional <= !ctrl[`CTRL_REF_HALF_OFF] || any_cal; // RULE6 RULE11
      for (int c = 0; c < CHANNELS; c++) begin
        low_side_ref_select_neg[c] <= ds_sense || ctrl[`CTRL_LOW_SIDE_REF_SELECT]; // RULE4 RULE14
        amp_inputs_shorted[c] <= cal_active[c] || (ds_sense && ls_off[c]); // RULE7 RULE9 RULE15
        amp_load_disconnect[c] <= cal_active[c]; // RULE7 RULE9
        amp_trim_run[c] <= cal_st[c] == CAL_TRIM; // RULE8
        pos_to_switch_node[c] <= ds_sense; // RULE13
        // in sense mode the amplifier waits for the drive window to end
        amp_enable[c] <= !ds_sense || (!drive_win[c] && !ls_off[c]); // RULE15
      end
    end
  end

  // assertions
  a_gain_forced_cal: assert property (@(posedge clk) disable iff (!rst_n)
    any_cal |=> amp_gain == `GAIN_CAL_CODE) else $error("gain not forced in cal"); // RULE7
  a_ref_bidir_cal: assert property (@(posedge clk) disable iff (!rst_n)
    any_cal |=> ref_bidirectional) else $error("reference not bidirectional in cal"); // RULE11
  a_ds_ref_neg: assert property (@(posedge clk) disable iff (!rst_n)
    ds_sense |=> &low_side_ref_select_neg) else $error("sense mode reference wrong"); // RULE14
  a_trip_no_glitch: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(overcurrent[0]) |-> $past(trip[0], 2) && $past(trip[0])) else $error("overcurrent too early"); // RULE1
  a_gain_restore: assert property (@(posedge clk) disable iff (!rst_n)
    !any_cal |=> amp_gain == $past(ctrl[`CTRL_GAIN_LSB +: 2])) else $error("gain not restored"); // RULE10
  sequence s_cal_start;
    cal_st[0] == CAL_IDLE ##1 cal_st[0] == CAL_TRIM;
  endsequence
  a_trim_len: assert property (@(posedge clk) disable iff (!rst_n)
    s_cal_start |=> cal_st[0] == CAL_TRIM || !$past(cal_req[0])) else $error("trim ended early"); // RULE8
  // independent count of cycles spent trimming on channel 0
  logic [CW-1:0] trim_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) trim_seen <= '0;
    else if (cal_st[0] == CAL_TRIM) trim_seen <= trim_seen + 1'b1;
    else trim_seen <= '0;
  end
  a_trim_exact: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    cal_st[0] == CAL_TRIM ##1 cal_st[0] == CAL_HOLD |-> $past(trim_seen) == CW'(TRIM_CYCLES - 1))
    else $error("trim length wrong");
  a_hold_stays: assert property (@(posedge clk) disable iff (!rst_n)
    cal_st[0] == CAL_HOLD && cal_req[0] |=> cal_st[0] == CAL_HOLD) else $error("hold lost"); // RULE9
  a_short_cal: assert property (@(posedge clk) disable iff (!rst_n)
    cal_active[0] |=> amp_inputs_shorted[0] && amp_load_disconnect[0]) else $error("cal not shorted"); // RULE7
  a_ds_route: assert property (@(posedge clk) disable iff (!rst_n)
    ds_sense |=> pos_to_switch_node == {CHANNELS{1'b1}}) else $error("switch node not routed"); // RULE13
  a_ds_off_short: assert property (@(posedge clk) disable iff (!rst_n)
    ds_sense && ls_off[0] |=> amp_inputs_shorted[0]) else $error("not shorted when off"); // RULE15
endmodule : shunt_amp_cal_and_vds_monitor_ctrl
`default_nettype wire

/* File: hdl/shunt_amp_defs.svh */
`ifndef SHUNT_AMP_DEFS_SVH
`define SHUNT_AMP_DEFS_SVH
// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_CAL 8'h04
`define REG_STATUS 8'h08
`define REG_DEGLITCH 8'h0c
// control field positions
`define CTRL_GAIN_LSB 0
`define CTRL_REF_HALF_OFF 2
`define CTRL_LOW_SIDE_REF_SELECT 3
`define CTRL_DS_SENSE 4
`define CTRL_TRIP_LSB 8
`define CTRL_FAULT_MODE_LSB 13
// reset values
`define CTRL_RESET 32'h0000_0000
`define DEGLITCH_RESET 16'h00fa
// gain code forced during calibration: 40 V/V
`define GAIN_CAL_CODE 2'h3
// timing
`define CLK_MHZ 250
`define TRIM_TIME_US 100
`define TRIM_CYCLES (`TRIM_TIME_US * `CLK_MHZ)
`define IN_DEGLITCH_CYCLES 4
`endif

/* File: hdl/shunt_amp_pkg.sv */
package shunt_amp_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_TRIM = 2'b01,
    CAL_HOLD = 2'b10
  } cal_state_t;
  typedef enum logic [1:0] {
    GAIN_5 = 2'b00,
    GAIN_10 = 2'b01,
    GAIN_20 = 2'b10,
    GAIN_40 = 2'b11
  } gain_t;
endpackage : shunt_amp_pkg
